// ===== shared/mapcsw_pkg.sv
// constants for the memory access port control and status word block
// assumes one system clock and an access request port driven by the debug port
//
// Summary of operation
// - control and status word sits at register offset zero, bank zero word zero.
// - optional bit 31 debug software access flag, readable and writable.
// - optional bits 30:24 protection field, forwarded on memory accesses.
// - read-only bit 23 shows secure privileged debug status.
// - mode, increment and width fields need no defined reset value.
// - read-only bit 7 is one while a memory-side transfer is active.
// - after abort, bit 7 still follows memory-side state.
// - read-only bit 6 mirrors the device enable input.
// - without a device enable input, bit 6 reads one.
// - bits 5:4 select address auto-increment and packing mode.
// - bits 2:0 select access width, writable when sub-word sizes exist.
// - word-only device makes width read-only, returning word encoding.
// - unsupported optional fields ignore writes and read zero, except bit 6, which reads one.
// - accessing this register never starts a memory transaction.
package mapcsw_pkg;
    localparam logic [3:0] MAPCSW_BANK_CSW = 4'h0;
    localparam logic [1:0] MAPCSW_WORD_CSW = 2'h0;
    localparam logic [7:0] MAPCSW_OFFSET_CSW = 8'h00;
    localparam int MAPCSW_SWEN_BIT = 31;
    localparam int MAPCSW_PROT_HI = 30;
    localparam int MAPCSW_PROT_LO = 24;
    localparam int MAPCSW_SPD_BIT = 23;
    localparam int MAPCSW_MODE_HI = 11;
    localparam int MAPCSW_MODE_LO = 8;
    localparam int MAPCSW_TRACT_BIT = 7;
    localparam int MAPCSW_DEVEN_BIT = 6;
    localparam int MAPCSW_INC_HI = 5;
    localparam int MAPCSW_INC_LO = 4;
    localparam int MAPCSW_SIZE_HI = 2;
    localparam int MAPCSW_SIZE_LO = 0;
    localparam logic [2:0] MAPCSW_SIZE_WORD = 3'h2;
    localparam logic [3:0] MAPCSW_MODE_NORMAL = 4'h0;
    // reset values of the unpredictable fields: any value is legal
    localparam logic [3:0] MAPCSW_MODE_RST = 4'h0;
    localparam logic [1:0] MAPCSW_INC_RST = 2'h0;
    localparam logic [2:0] MAPCSW_SIZE_RST = 3'h2;
    localparam logic MAPCSW_SWEN_RST = 1'b0;
    localparam logic [6:0] MAPCSW_PROT_RST = 7'h00;
    localparam logic [31:0] MAPCSW_ZERO_WORD = 32'h0000_0000;
endpackage : mapcsw_pkg

// ===== design/mapcsw_sync.sv
// two-flop synchroniser for one level input
// assumes the input may change at any time relative to sys_clk_i
module mapcsw_sync (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic rst_val_i,
    input wire logic async_i,
    output logic sync_o
);
    typedef struct packed {
        logic first;
        logic second;
    } mapcsw_sync_t;
    mapcsw_sync_t s_reg;
    mapcsw_sync_t s_next;

    always_comb begin
        s_next.first = async_i;
        s_next.second = s_reg.first;
    end

    // reset to constant zero; rst_val_i selects the polarity seen at the output
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_o = s_reg.second ^ rst_val_i;
endmodule : mapcsw_sync

// ===== design/mapcsw_top.sv
// control and status word register of a debug memory access port
// assumes a register access port from the debug port, one cycle per access,
// and a memory-side engine reporting its busy level
module mapcsw_top #(
    parameter bit HAS_SWEN = 1'b1,
    parameter bit HAS_PROT = 1'b1,
    parameter bit HAS_SPD = 1'b1,
    parameter bit HAS_DEVEN = 1'b1,
    parameter bit HAS_SUBWORD = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [3:0] acc_bank_i,
    input wire logic [1:0] acc_word_i,
    input wire logic [31:0] acc_wdata_i,
    output logic acc_ack_o,
    output logic [31:0] acc_rdata_o,
    output logic acc_hit_o,
    input wire logic mem_busy_i,
    input wire logic device_enable_input_i,
    input wire logic secure_privileged_debug_i,
    output logic debug_software_access_flag_o,
    output logic [6:0] mem_prot_o,
    output logic [3:0] mem_mode_o,
    output logic [1:0] address_increment_mode_o,
    output logic [2:0] mem_size_o,
    output logic mem_start_o
);
    import mapcsw_pkg::*;

    typedef struct packed {
        logic swen;
        logic [6:0] prot;
        logic spd;
        logic [3:0] mode;
        logic tract;
        logic deven;
        logic [1:0] inc;
        logic [2:0] size;
        logic ack;
        logic hit;
        logic [31:0] rdata;
    } mapcsw_state_t;

    mapcsw_state_t st_reg;
    mapcsw_state_t st_next;
    logic deven_sync;
    logic spd_sync;
    logic busy_sync;
    logic sel_csw;
    logic [31:0] csw_view;

    mapcsw_sync u_sync_deven (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .rst_val_i(1'b0),
        .async_i(device_enable_input_i),
        .sync_o(deven_sync)
    );
    mapcsw_sync u_sync_spd (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .rst_val_i(1'b0),
        .async_i(secure_privileged_debug_i),
        .sync_o(spd_sync)
    );
    mapcsw_sync u_sync_busy (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .rst_val_i(1'b0),
        .async_i(mem_busy_i),
        .sync_o(busy_sync)
    );

    // bank zero, word zero selects the control and status word
    assign sel_csw = acc_valid_i && (acc_bank_i == MAPCSW_BANK_CSW)
        && (acc_word_i == MAPCSW_WORD_CSW);

    always_comb begin
        csw_view = MAPCSW_ZERO_WORD;
        csw_view[MAPCSW_SWEN_BIT] = st_reg.swen;
        csw_view[MAPCSW_PROT_HI:MAPCSW_PROT_LO] = st_reg.prot;
        csw_view[MAPCSW_SPD_BIT] = st_reg.spd;
        csw_view[MAPCSW_MODE_HI:MAPCSW_MODE_LO] = st_reg.mode;
        csw_view[MAPCSW_TRACT_BIT] = st_reg.tract;
        csw_view[MAPCSW_DEVEN_BIT] = st_reg.deven;
        csw_view[MAPCSW_INC_HI:MAPCSW_INC_LO] = st_reg.inc;
        csw_view[MAPCSW_SIZE_HI:MAPCSW_SIZE_LO] = st_reg.size;
    end

    always_comb begin
        st_next = st_reg;
        // live status, independent of written data and of aborts
        st_next.tract = busy_sync;
        st_next.deven = HAS_DEVEN ? deven_sync : 1'b1;
        st_next.spd = HAS_SPD ? spd_sync : 1'b0;
        st_next.ack = acc_valid_i;
        st_next.hit = sel_csw;
        st_next.rdata = sel_csw && !acc_write_i ? csw_view : MAPCSW_ZERO_WORD;
        if (sel_csw && acc_write_i) begin
            if (HAS_SWEN) begin
                st_next.swen = acc_wdata_i[MAPCSW_SWEN_BIT];
            end
            if (HAS_PROT) begin
                st_next.prot = acc_wdata_i[MAPCSW_PROT_HI:MAPCSW_PROT_LO];
            end
            // nonzero mode is stored as written; software must keep it zero
            st_next.mode = acc_wdata_i[MAPCSW_MODE_HI:MAPCSW_MODE_LO];
            st_next.inc = acc_wdata_i[MAPCSW_INC_HI:MAPCSW_INC_LO];
            if (HAS_SUBWORD) begin
                st_next.size = acc_wdata_i[MAPCSW_SIZE_HI:MAPCSW_SIZE_LO];
            end
        end
        if (!HAS_SUBWORD) begin
            st_next.size = MAPCSW_SIZE_WORD;
        end
    end

    // unpredictable fields still get a fixed reset for clean simulation
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg.swen <= MAPCSW_SWEN_RST;
            st_reg.prot <= MAPCSW_PROT_RST;
            st_reg.spd <= 1'b0;
            st_reg.mode <= MAPCSW_MODE_RST;
            st_reg.tract <= 1'b0;
            // without the enable input the bit reads one from the first cycle on
            st_reg.deven <= !HAS_DEVEN;
            st_reg.inc <= MAPCSW_INC_RST;
            st_reg.size <= MAPCSW_SIZE_RST;
            st_reg.ack <= 1'b0;
            st_reg.hit <= 1'b0;
            st_reg.rdata <= MAPCSW_ZERO_WORD;
        end else begin
            st_reg <= st_next;
        end
    end

    assign acc_ack_o = st_reg.ack;
    assign acc_rdata_o = st_reg.rdata;
    assign acc_hit_o = st_reg.hit;
    assign debug_software_access_flag_o = st_reg.swen;
    assign mem_prot_o = st_reg.prot;
    assign mem_mode_o = st_reg.mode;
    assign address_increment_mode_o = st_reg.inc;
    assign mem_size_o = st_reg.size;
    // this register never launches a memory access
    assign mem_start_o = 1'b0;

    a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        st_reg.ack && !st_reg.hit |-> st_reg.rdata == MAPCSW_ZERO_WORD)
        else $error("unmapped or reserved read not zero");
    a_read_busy: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        sel_csw && !acc_write_i |=> acc_rdata_o[MAPCSW_TRACT_BIT] == $past(busy_sync, 2))
        else $error("transfer active bit wrong on read");
    a_busy_follow: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $rose(mem_busy_i) ##1 mem_busy_i [*2] |=> st_reg.tract)
        else $error("transfer active not following memory side");
    a_deven_mirror: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        ##1 st_reg.deven == (HAS_DEVEN ? $past(deven_sync) : 1'b1))
        else $error("device enable bit not mirrored");
    a_no_mem_start: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        sel_csw |=> !mem_start_o)
        else $error("control word access started a transfer");
    a_write_inc: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        sel_csw && acc_write_i |=> address_increment_mode_o == $past(acc_wdata_i[5:4]))
        else $error("increment mode not written");
    a_size_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        sel_csw && acc_write_i |=>
        mem_size_o == (HAS_SUBWORD ? $past(acc_wdata_i[2:0]) : MAPCSW_SIZE_WORD))
        else $error("size field wrong after write");
    a_status_kept: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        sel_csw && acc_write_i ##1 sel_csw && !acc_write_i
        |=> acc_rdata_o[MAPCSW_DEVEN_BIT] == $past(st_reg.deven))
        else $error("status bit taken from written data");
    a_prot_out: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        sel_csw && acc_write_i && HAS_PROT |=> mem_prot_o == $past(acc_wdata_i[30:24]))
        else $error("protection field not forwarded");

    // access steps seen by the properties below
    sequence s_csw_write;
        sel_csw && acc_write_i;
    endsequence

    sequence s_csw_read;
        sel_csw && !acc_write_i;
    endsequence

    a_ack_answer: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        acc_valid_i
        |=> acc_ack_o)
        else $error("access not answered");

    a_ack_quiet: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !acc_valid_i
        |=> !acc_ack_o && !acc_hit_o)
        else $error("answer without request");

    a_hit_decode: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        acc_valid_i
        |=> acc_hit_o == $past(acc_bank_i == MAPCSW_BANK_CSW && acc_word_i == MAPCSW_WORD_CSW))
        else $error("control word decode wrong");

    a_write_no_data: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_csw_write
        |=> acc_rdata_o == MAPCSW_ZERO_WORD)
        else $error("write returned data");

    a_fields_held: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !(sel_csw && acc_write_i)
        |=> $stable(mem_mode_o) && $stable(address_increment_mode_o))
        else $error("mode or increment changed without write");

    a_size_held: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !(sel_csw && acc_write_i)
        |=> $stable(mem_size_o) && $stable(mem_prot_o))
        else $error("size or protection changed without write");

    a_reserved_bits: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_csw_read
        |=> acc_rdata_o[22:12] == 11'h000)
        else $error("reserved high bits not zero");

    a_bit3_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_csw_read
        |=> !acc_rdata_o[3])
        else $error("reserved bit 3 not zero");

    a_other_quiet: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        acc_valid_i && !sel_csw
        |=> acc_rdata_o == MAPCSW_ZERO_WORD)
        else $error("other address returned data");

    a_spd_read: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_csw_read
        |=> acc_rdata_o[MAPCSW_SPD_BIT] == (HAS_SPD ? $past(spd_sync, 2) : 1'b0))
        else $error("secure debug bit wrong on read");

    a_spd_absent: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !HAS_SPD
        |-> !st_reg.spd)
        else $error("absent secure debug bit not zero");

    a_deven_read: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_csw_read
        |=> acc_rdata_o[MAPCSW_DEVEN_BIT] == (HAS_DEVEN ? $past(deven_sync, 2) : 1'b1))
        else $error("device enable bit wrong on read");

    a_deven_absent: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !HAS_DEVEN
        |-> st_reg.deven)
        else $error("absent device enable not one");

    a_swen_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_csw_write
        |=> debug_software_access_flag_o == (HAS_SWEN ? $past(acc_wdata_i[31]) : 1'b0))
        else $error("software access flag wrong after write");

    a_mode_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_csw_write
        |=> mem_mode_o == $past(acc_wdata_i[11:8]))
        else $error("mode field not written");

    a_width_fixed: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !HAS_SUBWORD
        |-> mem_size_o == MAPCSW_SIZE_WORD)
        else $error("word-only width not fixed");

    a_prot_absent: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !HAS_PROT
        |-> mem_prot_o == 7'h00)
        else $error("absent protection field not zero");

    a_inc_echo: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_csw_write ##1 s_csw_read
        |=> acc_rdata_o[5:4] == $past(acc_wdata_i[5:4], 2))
        else $error("increment mode not read back");

    a_size_echo: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_csw_write ##1 s_csw_read
        |=> acc_rdata_o[2:0] == (HAS_SUBWORD ? $past(acc_wdata_i[2:0], 2) : MAPCSW_SIZE_WORD))
        else $error("size field not read back");

    a_busy_drop: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $fell(mem_busy_i) ##1 !mem_busy_i [*2]
        |=> !st_reg.tract)
        else $error("transfer active not clearing");

    a_tract_live: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        1'b1
        |=> st_reg.tract == $past(busy_sync))
        else $error("transfer active not live");

    a_start_idle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        acc_valid_i
        |-> !mem_start_o)
        else $error("access launched a memory transfer");
endmodule : mapcsw_top

// ===== verification/mapcsw_dp_model.sv
// debug port model: issues one register access at a time
// assumes the block answers one cycle after the request edge
module mapcsw_dp_model (
    input wire logic sys_clk_i,
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic [3:0] acc_bank_o,
    output logic [1:0] acc_word_o,
    output logic [31:0] acc_wdata_o,
    input wire logic acc_ack_i,
    input wire logic acc_hit_i,
    input wire logic [31:0] acc_rdata_i,
    input wire logic [31:0] alt_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        acc_valid_o = 1'b0;
        acc_write_o = 1'b0;
        acc_bank_o = 4'h0;
        acc_word_o = 2'h0;
        acc_wdata_o = 32'h0000_0000;
    end
    task automatic access(input logic wr, input logic [3:0] bank, input logic [1:0] word,
            input logic [31:0] wd, output logic [31:0] rd, output logic [31:0] alt,
            output logic hit, output logic ack);
        @(negedge sys_clk_i);
        acc_valid_o = 1'b1;
        acc_write_o = wr;
        acc_bank_o = bank;
        acc_word_o = word;
        acc_wdata_o = wd;
        if (bank == 4'h0 && word == 2'h0) begin
            acc_wdata_o[11:8] = 4'h0;
        end
        @(negedge sys_clk_i);
        // released lines carry the inverse so a stale value is never trusted
        acc_valid_o = 1'b0;
        acc_write_o = ~wr;
        acc_bank_o = ~bank;
        acc_word_o = ~word;
        acc_wdata_o = ~wd;
        ack = acc_ack_i;
        hit = acc_hit_i;
        rd = acc_rdata_i;
        alt = alt_rdata_i;
    endtask : access
endmodule : mapcsw_dp_model

// ===== verification/mapcsw_top_tb_top.sv
// testbench: full-featured block and a minimal build share one request port
// assumes the model drives requests and status inputs change at falling edges
module mapcsw_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, nrst, vld, wr, ack, hit, busy, deven, spd, swen, start;
    logic [3:0] bank, mode;
    logic [1:0] word, inc;
    logic [31:0] wd, rdata, rdata_b, ra, rb;
    logic [6:0] prot;
    logic [2:0] size;
    logic rh, rk;
    int error_cnt = 0;
    int samples_checked = 0;
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    mapcsw_top dut (.sys_clk_i(sys_clk), .nrst_i(nrst), .acc_valid_i(vld), .acc_write_i(wr),
        .acc_bank_i(bank), .acc_word_i(word), .acc_wdata_i(wd), .acc_ack_o(ack),
        .acc_rdata_o(rdata), .acc_hit_o(hit), .mem_busy_i(busy),
        .device_enable_input_i(deven), .secure_privileged_debug_i(spd),
        .debug_software_access_flag_o(swen), .mem_prot_o(prot), .mem_mode_o(mode),
        .address_increment_mode_o(inc), .mem_size_o(size), .mem_start_o(start));
    mapcsw_top #(.HAS_SWEN(1'b0), .HAS_PROT(1'b0), .HAS_SPD(1'b0), .HAS_DEVEN(1'b0),
        .HAS_SUBWORD(1'b0)) dut_min (.sys_clk_i(sys_clk), .nrst_i(nrst), .acc_valid_i(vld),
        .acc_write_i(wr), .acc_bank_i(bank), .acc_word_i(word), .acc_wdata_i(wd),
        .acc_ack_o(), .acc_rdata_o(rdata_b), .acc_hit_o(), .mem_busy_i(busy),
        .device_enable_input_i(deven), .secure_privileged_debug_i(spd),
        .debug_software_access_flag_o(), .mem_prot_o(), .mem_mode_o(),
        .address_increment_mode_o(), .mem_size_o(), .mem_start_o());
    mapcsw_dp_model model (.sys_clk_i(sys_clk), .acc_valid_o(vld), .acc_write_o(wr),
        .acc_bank_o(bank), .acc_word_o(word), .acc_wdata_o(wd), .acc_ack_i(ack),
        .acc_hit_i(hit), .acc_rdata_i(rdata), .alt_rdata_i(rdata_b));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [3:0] b, input logic [1:0] a,
            input logic [31:0] d);
        model.access(w, b, a, d, ra, rb, rh, rk);
        check("ack", 32'h0000_0001, {31'h0, rk});
    endtask : xfer
    task automatic settle();
        repeat (4) @(negedge sys_clk);
    endtask : settle
    task automatic t_reset();
        xfer(1'b0, 4'h0, 2'h0, 32'h0000_0000);
        check("reset word", 32'h0000_0042, ra);
        check("hit", 32'h0000_0001, {31'h0, rh});
        check("minimal word", 32'h0000_0042, rb);
    endtask : t_reset
    task automatic t_write();
        xfer(1'b1, 4'h0, 2'h0, 32'hFFFF_FFFF);
        check("write rdata", 32'h0000_0000, ra);
        check("config ports", {15'h0, 17'h1_FE1F}, {15'h0, swen, prot, mode, inc, size});
        xfer(1'b0, 4'h0, 2'h0, 32'h0000_0000);
        check("full word", 32'hFF00_0077, ra);
        check("minimal full", 32'h0000_0072, rb);
        xfer(1'b1, 4'h0, 2'h0, 32'h0000_0002);
    endtask : t_write
    task automatic t_status();
        @(negedge sys_clk);
        busy = 1'b1;
        spd = 1'b1;
        deven = 1'b0;
        settle();
        xfer(1'b1, 4'h0, 2'h0, 32'h0000_0002);
        xfer(1'b0, 4'h0, 2'h0, 32'h0000_0000);
        check("busy word", 32'h0080_0082, ra);
        check("minimal busy", 32'h0000_00C2, rb);
        busy = 1'b0;
        settle();
        xfer(1'b0, 4'h0, 2'h0, 32'h0000_0000);
        check("idle word", 32'h0080_0002, ra);
        spd = 1'b0;
        deven = 1'b1;
        settle();
    endtask : t_status
    task automatic t_other();
        logic [5:0] addr[3] = '{6'h01, 6'h04, 6'h3F};
        foreach (addr[i]) begin
            xfer(1'b1, addr[i][5:2], addr[i][1:0], 32'hFFFF_FFFF);
            xfer(1'b0, addr[i][5:2], addr[i][1:0], 32'h0000_0000);
            check("other hit", 32'h0000_0000, {31'h0, rh});
            check("other rdata", 32'h0000_0000, ra);
        end
        xfer(1'b0, 4'h0, 2'h0, 32'h0000_0000);
        check("kept word", 32'h0000_0042, ra);
    endtask : t_other
    always @(negedge sys_clk) begin
        if (nrst && start !== 1'b0) begin
            error_cnt++;
            $display("BAD mem_start expected 0 seen %b", start);
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (2000) @(posedge sys_clk);
        error_cnt++;
        $display("BAD watchdog expected done seen hang");
        final_report();
    end
    initial begin
        nrst = 1'b0;
        busy = 1'b0;
        spd = 1'b0;
        deven = 1'b1;
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        settle();
        t_reset();
        t_write();
        t_status();
        t_other();
        final_report();
    end
endmodule : mapcsw_top_tb_top
